// [tpgs_sequencer.sv]
// top: supply qualification, soft start launch, reset delay and power good flag
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module tpgs_sequencer
	import tpgs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] channel_enable,
	input wire logic [2:0] fb_above_85,
	input wire logic [2:0] fb_above_80,
	input wire logic input_above_internal_start,
	input wire logic input_above_pump_start,
	input wire logic input_above_internal_stop,
	input wire logic input_above_external_stop,
	input wire logic input_above_warning,
	input wire logic external_logic_supply,
	input wire logic bias_ok,
	input wire logic thermal_shutdown,
	output logic power_good_reset_n,
	output logic power_good_reset_n_oe,
	output logic charge_pump_enable,
	output logic [2:0] channel_run,
	output logic [2:0] channel_soft_start
);
	typedef struct packed
	{
		tpgs_seq_t seq;
		logic [31:0] dly_cnt;
		logic input_up;
		logic pump_up;
		logic [2:0] en_q;
		logic [2:0] run_q;
		logic [2:0] ramp_q;
		logic pg;
		logic pump_en;
	} tpgs_seq_state_t;
	tpgs_seq_state_t cur_ff;
	tpgs_seq_state_t nxt_cur;
	logic [2:0] sw_enable;
	logic [31:0] delay_len;
	logic [31:0] ss_len;
	logic [31:0] status;
	logic [2:0] en_eff;
	logic [2:0] running;
	logic [2:0] ramping;
	logic [2:0] go;
	logic stop_ok;
	logic shutdown;
	logic all_85;
	logic any_below_80;
	logic new_enable;
	logic drop;

	tpgs_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.status(status),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sw_enable(sw_enable),
		.delay_len(delay_len),
		.ss_len(ss_len)
	);

	// one soft start unit per channel, each with its own counter
	genvar gi;
	generate
		for (gi = 0; gi < TPGS_NCH; gi++)
		begin : g_ch
			tpgs_ss_if ssi ();
			assign ssi.go = go[gi];
			assign ssi.ramp_len = ss_len;
			assign running[gi] = ssi.running;
			assign ramping[gi] = ssi.ramping;
			tpgs_soft_start u_ss (
				.pclk(pclk),
				.presetn(presetn),
				.ss(ssi.chan)
			);
		end
	endgenerate

	// supply and channel qualification terms
	always_comb
	begin
		en_eff = channel_enable | sw_enable;
		// threshold set follows logic supply source
		stop_ok = external_logic_supply ? input_above_external_stop
			: input_above_internal_stop;
		shutdown = thermal_shutdown || !stop_ok || !bias_ok;
		// go depends on enable, supplies, bias and thermal shutdown only, never on feedback
		go = (cur_ff.pump_up && !shutdown) ? en_eff : 3'b000;
		all_85 = ((fb_above_85 & en_eff) == en_eff);
		any_below_80 = |(~fb_above_80 & en_eff);
		new_enable = |(en_eff & ~cur_ff.en_q);
		drop = any_below_80 || new_enable || (en_eff == 3'b000)
			|| !input_above_warning || shutdown;
	end

	// supply bring-up, delay counter and flag
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.en_q = en_eff;
		nxt_cur.run_q = running;
		nxt_cur.ramp_q = ramping;
		// start from internal threshold until external logic supply is present
		if (!cur_ff.input_up)
			nxt_cur.input_up = external_logic_supply ? input_above_pump_start
				: input_above_internal_start;
		else if (!stop_ok)
			nxt_cur.input_up = 1'b0;
		nxt_cur.pump_en = nxt_cur.input_up;
		if (!cur_ff.pump_en)
			nxt_cur.pump_up = 1'b0;
		else if (input_above_pump_start)
			nxt_cur.pump_up = 1'b1;
		unique case (cur_ff.seq)
			TPGS_OFF:
				if (en_eff != 3'b000)
					nxt_cur.seq = TPGS_WAIT;
			TPGS_WAIT:
				if (en_eff == 3'b000)
					nxt_cur.seq = TPGS_OFF;
				else if (!drop && all_85)
				begin
					nxt_cur.seq = TPGS_DELAY;
					nxt_cur.dly_cnt = delay_len;
				end
			TPGS_DELAY:
				if (drop || !all_85)
				begin
					nxt_cur.seq = (en_eff == 3'b000) ? TPGS_OFF : TPGS_WAIT;
					nxt_cur.dly_cnt = 32'h0000_0000;
				end
				else if (cur_ff.dly_cnt <= 32'h0000_0001)
				begin
					nxt_cur.seq = TPGS_GOOD;
					nxt_cur.dly_cnt = 32'h0000_0000;
				end
				else
					nxt_cur.dly_cnt = cur_ff.dly_cnt - 32'h0000_0001;
			TPGS_GOOD:
				if (drop)
					nxt_cur.seq = (en_eff == 3'b000) ? TPGS_OFF : TPGS_WAIT;
		endcase
		nxt_cur.pg = (nxt_cur.seq == TPGS_GOOD);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur_ff <= '{seq: TPGS_OFF, dly_cnt: 32'h0000_0000, input_up: 1'b0,
				pump_up: 1'b0, en_q: 3'h0, run_q: 3'h0, ramp_q: 3'h0, pg: 1'b0,
				pump_en: 1'b0};
		else
			cur_ff <= nxt_cur;
	end

	// open drain flag: enable is active low, so drive low whenever not good
	assign power_good_reset_n = 1'b0;
	assign power_good_reset_n_oe = cur_ff.pg;
	assign charge_pump_enable = cur_ff.pump_en;
	assign channel_run = cur_ff.run_q;
	assign channel_soft_start = cur_ff.ramp_q;
	assign status = {20'h0, cur_ff.seq, external_logic_supply, shutdown, cur_ff.pump_up,
		cur_ff.pg, fb_above_85 & en_eff, cur_ff.run_q};

	// untimed sequences: each takes its clock from the property that uses it
	sequence s_all_good;
		all_85 && !drop;
	endsequence
	sequence s_wait_to_delay;
		cur_ff.seq == TPGS_WAIT ##1 cur_ff.seq == TPGS_DELAY;
	endsequence

	AST_DLY_START: assert property (@(posedge pclk) disable iff (!presetn)
		cur_ff.seq == TPGS_WAIT ##0 s_all_good |=> cur_ff.seq == TPGS_DELAY)
		else $error("delay did not start with all channels at startup level");
	AST_NO_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
		cur_ff.seq == TPGS_DELAY && !all_85 |=> !cur_ff.pg)
		else $error("flag rose with a channel below startup level");
	AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cur_ff.pg) |-> $past(cur_ff.seq) == TPGS_DELAY && !$past(any_below_80))
		else $error("flag released with a channel below 80 percent");
	AST_NEW_EN: assert property (@(posedge pclk) disable iff (!presetn)
		cur_ff.pg && new_enable |=> !cur_ff.pg ##1 go != 3'b000 || !cur_ff.pump_up)
		else $error("new enable did not drop the flag");
	AST_DROPOUT: assert property (@(posedge pclk) disable iff (!presetn)
		any_below_80 |=> !power_good_reset_n_oe)
		else $error("flag not dropped on dropout");
	AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		s_wait_to_delay |-> cur_ff.dly_cnt == $past(delay_len))
		else $error("delay not restarted from the beginning");
	AST_NO_RESTART_SS: assert property (@(posedge pclk) disable iff (!presetn)
		cur_ff.run_q[0] && en_eff[0] && !shutdown && cur_ff.pump_up ##1 !fb_above_80[0]
		|=> cur_ff.run_q[0])
		else $error("dropout restarted soft start");
	AST_LAST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		en_eff == 3'b000 |=> !cur_ff.pg)
		else $error("flag stayed high with no channel enabled");
	AST_WARN: assert property (@(posedge pclk) disable iff (!presetn)
		!input_above_warning && !shutdown && (go & running) != 3'b000
		|=> !cur_ff.pg && channel_run != 3'b000)
		else $error("warning level did not drop flag alone");
	AST_SHUTDOWN: assert property (@(posedge pclk) disable iff (!presetn)
		shutdown |=> running == 3'b000)
		else $error("channels not shut down on fault");
endmodule

// [tpgs_pkg.sv]
// package for the triple rail power good sequencer: map, fields, timing
package tpgs_pkg;
	// apb register byte offsets
	localparam logic [7:0] TPGS_CTRL_OFF = 8'h00;
	localparam logic [7:0] TPGS_DELAY_OFF = 8'h04;
	localparam logic [7:0] TPGS_STATUS_OFF = 8'h08;
	localparam logic [7:0] TPGS_SS_OFF = 8'h0C;
	localparam logic [7:0] TPGS_ID_OFF = 8'h10;
	// ctrl fields
	localparam int TPGS_CTRL_EN_LSB = 0;
	localparam logic [2:0] TPGS_CTRL_RST = 3'h0;
	// status field positions
	localparam int TPGS_ST_RUN_LSB = 0;
	localparam int TPGS_ST_GOOD_LSB = 3;
	localparam int TPGS_ST_PG_BIT = 6;
	localparam int TPGS_ST_PUMP_BIT = 7;
	localparam int TPGS_ST_SHDN_BIT = 8;
	localparam int TPGS_ST_EXTL_BIT = 9;
	localparam int TPGS_ST_SEQ_LSB = 10;
	// timing: clock rate and reset delay
	localparam int TPGS_CLK_MHZ = 200;
	localparam real TPGS_DELAY_S_PER_F = 2.131e5;
	localparam real TPGS_CAP_NF = 470.0;
	// delay cycles = s/F * C * f, rounded down as a longest time
	localparam int TPGS_DELAY_CYC = int'($floor(TPGS_DELAY_S_PER_F * TPGS_CAP_NF * 1.0e-9
		* TPGS_CLK_MHZ * 1.0e6));
	localparam logic [31:0] TPGS_DELAY_RST = 32'(TPGS_DELAY_CYC);
	localparam logic [31:0] TPGS_SS_RST = 32'h0000_1000;
	localparam int TPGS_NCH = 3;
	// sequencer states, gray along power-up path
	typedef enum logic [1:0]
	{
		TPGS_OFF = 2'b00,
		TPGS_WAIT = 2'b01,
		TPGS_DELAY = 2'b11,
		TPGS_GOOD = 2'b10
	} tpgs_seq_t;
	// per-channel soft start states
	typedef enum logic [1:0]
	{
		TPGS_CH_IDLE = 2'b00,
		TPGS_CH_RAMP = 2'b01,
		TPGS_CH_RUN = 2'b11
	} tpgs_ch_t;
endpackage

// [tpgs_ss_if.sv]
// carrier between the sequencer and its per-channel soft start units
`timescale 1ns/1ps
interface tpgs_ss_if;
	logic go;
	logic [31:0] ramp_len;
	logic running;
	logic ramping;
	modport seq (output go, output ramp_len, input running, input ramping);
	modport chan (input go, input ramp_len, output running, output ramping);
endinterface

// [tpgs_soft_start.sv]
// one channel soft start: ramps once per rise of go, holds through dropouts
`timescale 1ns/1ps
module tpgs_soft_start
	import tpgs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	tpgs_ss_if.chan ss
);
	typedef struct packed
	{
		tpgs_ch_t st;
		logic [31:0] cnt;
	} tpgs_ss_state_t;
	tpgs_ss_state_t cur_ff;
	tpgs_ss_state_t nxt_cur;

	// go drops on disable or global shutdown; a feedback dropout never clears it
	always_comb
	begin
		nxt_cur = cur_ff;
		unique case (cur_ff.st)
			TPGS_CH_IDLE:
				if (ss.go)
				begin
					nxt_cur.st = TPGS_CH_RAMP;
					nxt_cur.cnt = 32'h0000_0000;
				end
			TPGS_CH_RAMP:
				if (!ss.go)
					nxt_cur.st = TPGS_CH_IDLE;
				else if (cur_ff.cnt >= ss.ramp_len)
					nxt_cur.st = TPGS_CH_RUN;
				else
					nxt_cur.cnt = cur_ff.cnt + 32'h0000_0001;
			TPGS_CH_RUN:
				if (!ss.go)
					nxt_cur.st = TPGS_CH_IDLE;
			default:
				nxt_cur.st = TPGS_CH_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur_ff <= '{st: TPGS_CH_IDLE, cnt: 32'h0000_0000};
		else
			cur_ff <= nxt_cur;
	end

	assign ss.running = (cur_ff.st != TPGS_CH_IDLE);
	assign ss.ramping = (cur_ff.st == TPGS_CH_RAMP);

	AST_SS_STOP: assert property (@(posedge pclk) disable iff (!presetn)
		!ss.go |=> !ss.running) else $error("soft start kept running without go");
endmodule

// [tpgs_apb_regs.sv]
// apb slave holding control, delay, soft start length and status view
`timescale 1ns/1ps
module tpgs_apb_regs
	import tpgs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] status,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [2:0] sw_enable,
	output logic [31:0] delay_len,
	output logic [31:0] ss_len
);
	localparam logic [31:0] TPGS_ID_VAL = 32'h0000_5A01; // arbitrary value
	typedef struct packed
	{
		logic [2:0] en;
		logic [31:0] dly;
		logic [31:0] ss;
		logic [31:0] rd;
		logic err;
	} tpgs_reg_state_t;
	tpgs_reg_state_t cur_ff;
	tpgs_reg_state_t nxt_cur;
	logic acc;
	logic hit;

	// zero wait states: access phase completes at once
	always_comb
	begin
		nxt_cur = cur_ff;
		acc = psel && penable;
		hit = (paddr == TPGS_CTRL_OFF) || (paddr == TPGS_DELAY_OFF)
			|| (paddr == TPGS_STATUS_OFF) || (paddr == TPGS_SS_OFF) || (paddr == TPGS_ID_OFF);
		nxt_cur.err = 1'b0;
		if (psel && !penable)
		begin
			// read data registered in setup so it stands during access
			unique case (paddr)
				TPGS_CTRL_OFF: nxt_cur.rd = {29'h0, cur_ff.en};
				TPGS_DELAY_OFF: nxt_cur.rd = cur_ff.dly;
				TPGS_STATUS_OFF: nxt_cur.rd = status;
				TPGS_SS_OFF: nxt_cur.rd = cur_ff.ss;
				TPGS_ID_OFF: nxt_cur.rd = TPGS_ID_VAL;
				default: nxt_cur.rd = 32'h0000_0000;
			endcase
			nxt_cur.err = !hit;
		end
		if (acc && pwrite)
		begin
			if (paddr == TPGS_CTRL_OFF)
				nxt_cur.en = pwdata[TPGS_CTRL_EN_LSB +: 3];
			if (paddr == TPGS_DELAY_OFF)
				nxt_cur.dly = pwdata;
			if (paddr == TPGS_SS_OFF)
				nxt_cur.ss = pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur_ff <= '{en: TPGS_CTRL_RST, dly: TPGS_DELAY_RST, ss: TPGS_SS_RST,
				rd: 32'h0000_0000, err: 1'b0};
		else
			cur_ff <= nxt_cur;
	end

	assign prdata = cur_ff.rd;
	assign pready = 1'b1;
	assign pslverr = cur_ff.err;
	assign sw_enable = cur_ff.en;
	assign delay_len = cur_ff.dly;
	assign ss_len = cur_ff.ss;
endmodule

// [tpgs_host_ctrl.sv]
// host controller model: drives the channel enables and watches the flag
`timescale 1ns/1ps
module tpgs_host_ctrl
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flag,
	input wire logic [2:0] want,
	input wire logic refresh,
	output logic [2:0] channel_enable
);
	logic flag_ff;
	logic drop_ff;
	// remember the flag so a falling edge can trigger a fresh soft start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_ff <= 1'b0;
			drop_ff <= 1'b0;
		end
		else
		begin
			flag_ff <= flag;
			drop_ff <= refresh && flag_ff && !flag;
		end
	end
	// one low cycle on all enables, else the bench's wish per channel
	assign channel_enable = drop_ff ? 3'h0 : want;
endmodule

// [triple_rail_power_good_sequencer_bench.sv]
// self-checking bench for the power good sequencer with a host model
`timescale 1ns/1ps
module triple_rail_power_good_sequencer_bench
	import tpgs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] want = 3'h1;
	logic [2:0] fb85 = 3'h0;
	logic [2:0] fb80 = 3'h0;
	logic in_is = 1'b0, in_ps = 1'b1, in_ist = 1'b1, in_est = 1'b1, in_warn = 1'b1;
	logic ext = 1'b0, bias = 1'b1, therm = 1'b0, refresh = 1'b0;
	logic [31:0] prdata, rd, dly;
	logic pready, pslverr, pg_n, pg_oe, pump, flag, e;
	logic [2:0] chen, run, ss;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int c;
	always #2.5 pclk = ~pclk;
	// open drain with pull-up: released pin reads high
	assign flag = pg_oe ? 1'b1 : pg_n;
	tpgs_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_enable(chen), .fb_above_85(fb85), .fb_above_80(fb80),
		.input_above_internal_start(in_is), .input_above_pump_start(in_ps),
		.input_above_internal_stop(in_ist), .input_above_external_stop(in_est),
		.input_above_warning(in_warn), .external_logic_supply(ext), .bias_ok(bias),
		.thermal_shutdown(therm), .power_good_reset_n(pg_n), .power_good_reset_n_oe(pg_oe),
		.charge_pump_enable(pump), .channel_run(run), .channel_soft_start(ss));
	tpgs_host_ctrl host (.pclk(pclk), .presetn(presetn), .flag(flag), .want(want),
		.refresh(refresh), .channel_enable(chen));
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; idle cycle first so psel is never driven twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// flag sampled mid-cycle; c counts edges from the caller's edge
	task automatic wait_flag(input logic v);
		c = 0;
		@(negedge pclk);
		while (flag !== v && c < 4000)
		begin
			@(negedge pclk);
			c++;
		end
		@(posedge pclk);
	endtask
	task automatic wait_ss(input logic [2:0] v);
		int k;
		k = 0;
		@(negedge pclk);
		while (ss !== v && k < 40)
		begin
			@(negedge pclk);
			k++;
		end
		chk({29'h0, ss}, {29'h0, v});
		@(posedge pclk);
	endtask
	// hang guard: the whole run needs well under this many cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 6000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	initial
	begin
		void'($urandom(26));
		dly = 32'($urandom_range(20, 4));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, flag}, 32'h0);
		apb(1'b0, TPGS_DELAY_OFF, 32'h0);
		chk(rd, TPGS_DELAY_RST);
		apb(1'b0, TPGS_SS_OFF, 32'h0);
		chk(rd, TPGS_SS_RST);
		apb(1'b0, TPGS_CTRL_OFF, 32'h0);
		chk(rd, {29'h0, TPGS_CTRL_RST});
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], e}, 32'h1);
		apb(1'b1, TPGS_DELAY_OFF, dly);
		apb(1'b1, TPGS_SS_OFF, 32'h4);
		apb(1'b0, TPGS_DELAY_OFF, 32'h0);
		chk(rd, dly);
		// pump start alone is not enough without external logic supply
		chk({31'h0, pump}, 32'h0);
		in_is <= 1'b1;
		in_ps <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({28'h0, pump, run}, 32'h8);
		in_ps <= 1'b1;
		wait_ss(3'h1);
		repeat (8) @(posedge pclk);
		fb85 <= 3'h1;
		fb80 <= 3'h1;
		wait_flag(1'b1);
		chk(32'(c), dly + 1);
		want <= 3'h3;
		wait_flag(1'b0);
		chk(32'(c), 32'h1);
		wait_ss(3'h2);
		repeat (6) @(posedge pclk);
		fb85 <= 3'h3;
		fb80 <= 3'h3;
		wait_flag(1'b1);
		chk(32'(c), dly + 1);
		fb85 <= 3'h1;
		fb80 <= 3'h1;
		wait_flag(1'b0);
		chk(32'(c), 32'h1);
		repeat (4) @(posedge pclk);
		chk({26'h0, ss, run}, 32'h3);
		fb80 <= 3'h3;
		fb85 <= 3'h3;
		wait_flag(1'b1);
		chk(32'(c), dly + 1);
		for (int r = 0; r < 2; r++)
		begin
			refresh <= r[0];
			in_warn <= 1'b0;
			wait_flag(1'b0);
			chk(32'(c), 32'h1);
			if (r == 0)
				chk({29'h0, run}, 32'h3);
			else
				wait_ss(3'h3);
			in_warn <= 1'b1;
			refresh <= 1'b0;
			wait_flag(1'b1);
			chk({31'h0, flag}, 32'h1);
		end
		ext <= 1'b1;
		in_ist <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({28'h0, flag, run}, 32'hB);
		ext <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({28'h0, flag, run}, 32'h0);
		in_ist <= 1'b1;
		wait_ss(3'h3);
		therm <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({28'h0, flag, run}, 32'h0);
		therm <= 1'b0;
		wait_ss(3'h3);
		wait_flag(1'b1);
		apb(1'b1, TPGS_CTRL_OFF, 32'h4);
		wait_ss(3'h4);
		chk({31'h0, flag}, 32'h0);
		fb85 <= 3'h7;
		fb80 <= 3'h7;
		wait_flag(1'b1);
		chk(32'(c), dly + 1);
		apb(1'b1, TPGS_CTRL_OFF, 32'h0);
		repeat (4) @(posedge pclk);
		chk({28'h0, flag, run}, 32'hB);
		want <= 3'h0;
		wait_flag(1'b0);
		chk(32'(c), 32'h1);
		end_of_test();
	end
endmodule
